// ### verilog/rbl_consts.svh
// offsets, field positions, reset values and timing counts of the reset/boot block
// assumes a 100 MHz clock and an APB slave with 32-bit data
`ifndef RBL_CONSTS_SVH
`define RBL_CONSTS_SVH
`define RBL_OFF_BOOT_CTRL 12'h024
`define RBL_OFF_CPU_STATE 12'h028
`define RBL_OFF_CFG_STATE 12'h02C
`define RBL_OFF_TRIPLET 12'h030
`define RBL_OFF_RX_BYTE 12'h034
`define RBL_OFF_PC 12'h038
`define RBL_BIT_IGNORE_PINS 7
`define RBL_BOOT_CTRL_RESET 8'h00
`define RBL_ZERO16 16'h0000
`define RBL_IRQ_PRIO_RESET 8'hFF
`define RBL_CLK_DIV8 2'h3
`define RBL_BANK0_WAIT4 3'h4
`define RBL_RST_CYCLES 128
`define RBL_WDOG_MS 2000
`define RBL_CLK_HZ 100000000
`define RBL_WDOG_CYCLES (`RBL_WDOG_MS * (`RBL_CLK_HZ / 1000))
`define RBL_BAUD 2400
`define RBL_SLOW_HZ 32768
`define RBL_BAUD_TICKS ((`RBL_SLOW_HZ + `RBL_BAUD / 2) / `RBL_BAUD)
`endif

// ### verilog/rbl_pkg.sv
// types shared by the reset/boot block
// assumes nothing beyond the constants header
package rbl_pkg;
  typedef enum logic [1:0] {
    RBL_BOOT_NONE,
    RBL_BOOT_SLAVE,
    RBL_BOOT_SYNC,
    RBL_BOOT_ASYNC
  } rbl_boot_type;
  typedef enum logic [2:0] {
    RBL_ST_DRAIN,
    RBL_ST_HOLD,
    RBL_ST_SAMPLE,
    RBL_ST_RUN,
    RBL_ST_ADDR_HI,
    RBL_ST_ADDR_LO,
    RBL_ST_DATA
  } rbl_state_type;
endpackage

// ### verilog/rbl_reset_boot.sv
// reset sequencer and bootstrap triplet loader with its apb register slave
// assumes one 100 MHz clock; pins and the 32 kHz clock arrive asynchronously
//
// What this block does
// - reset restores all processor state except the real-time clock
// - a write in progress delays pin reset until that write ends; a watchdog bite resets at once
// - internal reset lasts at least 128 main clock cycles
// - during reset second chip select floats, other controls are high
// - reset indicator high in reset or powerdown, low otherwise
// - cpu and peripheral clocks leave reset dividing by eight
// - doubler off, bank zero on select zero, protected, four waits, 8-bit
// - pc zero; priority ff; watchdog set, secondary watchdog clear
// - sample boot pins after reset; 00 fetches from 0000 via select zero
// - any boot pin high enters bootstrap on serial channel or slave port
// - asynchronous boot times 2400 bps from 32 kHz; others need no slow clock
// - bootstrap suppresses boot memory fetch and runs the internal boot rom
// - triplet is address high byte, address low byte, then data byte
// - address top bit set writes an internal register instead of memory
// - every received byte reloads the watchdog with two seconds
// - returning to boot rom start re-samples the boot pins
// - control bit 7 set ignores boot pins, normal execution continues
// - clearing bit 7 re-enters boot when low four pc bits are zero
// - setting bit 7 after an in-line download resumes interrupted code
// - any bootstrap entry erases the encryption ram
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "rbl_consts.svh"
module rbl_reset_boot #(
  parameter int unsigned WDOG_CYCLES = `RBL_WDOG_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic powerdown,
  input wire logic write_busy,
  input wire logic boot_select_pin0,
  input wire logic boot_select_pin1,
  input wire logic slow_clk_32k,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic [15:0] cpu_pc,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic init_active_out,
  output logic mem_select0_n,
  output logic mem_read_strobe0_n,
  output logic mem_select1_n_o,
  output logic mem_select1_n_oe,
  output logic io_ctrl_n,
  output logic core_reset,
  output logic boot_rom_active,
  output logic [1:0] boot_port,
  output logic baud_tick,
  output logic boot_wr,
  output logic boot_wr_reg,
  output logic [15:0] boot_wr_addr,
  output logic [7:0] boot_wr_data,
  output logic crypt_ram_clear,
  output logic [1:0] cpu_clk_div,
  output logic [1:0] per_clk_div,
  output logic doubler_en,
  output logic [2:0] bank0_waits,
  output logic bank0_wprot,
  output logic mem_8bit,
  output logic [15:0] pc_init,
  output logic [7:0] irq_priority_level,
  output logic wdog_en,
  output logic sec_wdog_en,
  output logic wdog_expired
);
  // three-stage synchronisers for pins
  logic [2:0] rst_sync, p0_sync, p1_sync, slow_sync;
  logic rst_f, p0_f, p1_f;
  rbl_pkg::rbl_state_type state;
  rbl_pkg::rbl_state_type next_state;
  logic [7:0] rst_cnt;
  logic [7:0] slave_port_boot_control;
  logic [7:0] addr_hi;
  logic [31:0] wdog_cnt;
  logic [3:0] baud_cnt;
  logic [1:0] boot_mode;

  function automatic logic agree(input logic [2:0] s, input logic prev);
    agree = (s[2] == s[1]) ? s[1] : prev;
  endfunction

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rst_sync <= 3'h7;
      p0_sync <= 3'h0;
      p1_sync <= 3'h0;
      slow_sync <= 3'h0;
      rst_f <= 1'b1;
      p0_f <= 1'b0;
      p1_f <= 1'b0;
    end else begin
      rst_sync <= {rst_sync[1:0], reset_pin_n};
      p0_sync <= {p0_sync[1:0], boot_select_pin0};
      p1_sync <= {p1_sync[1:0], boot_select_pin1};
      slow_sync <= {slow_sync[1:0], slow_clk_32k};
      rst_f <= agree(rst_sync, rst_f);
      p0_f <= agree(p0_sync, p0_f);
      p1_f <= agree(p1_sync, p1_f);
    end
  end

  // decode of apb and sequence conditions
  wire [11:0] reg_addr = paddr[11:0];
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pready && pwrite;
  wire hit_ctrl = reg_addr == `RBL_OFF_BOOT_CTRL;
  wire hit_ok = (paddr[31:12] == 20'h0_0000) && (hit_ctrl
    || reg_addr == `RBL_OFF_CPU_STATE || reg_addr == `RBL_OFF_CFG_STATE
    || reg_addr == `RBL_OFF_TRIPLET || reg_addr == `RBL_OFF_RX_BYTE
    || reg_addr == `RBL_OFF_PC);
  wire ctrl_wr = apb_wr && hit_ctrl;
  wire new_ignore = pwdata[`RBL_BIT_IGNORE_PINS];
  wire reset_req = !rst_f;
  wire reset_now = !write_busy; // drain ends once the write is done
  wire in_reset = state == rbl_pkg::RBL_ST_HOLD; // a pending write keeps drain out of reset
  wire [1:0] pins_now = {p1_f, p0_f};
  wire ignore = slave_port_boot_control[`RBL_BIT_IGNORE_PINS];
  wire in_boot = state == rbl_pkg::RBL_ST_ADDR_HI || state == rbl_pkg::RBL_ST_ADDR_LO
    || state == rbl_pkg::RBL_ST_DATA;
  wire reentry = state == rbl_pkg::RBL_ST_RUN && !ignore && cpu_pc[3:0] == 4'h0
    && pins_now != 2'h0;
  wire enter_boot = state == rbl_pkg::RBL_ST_SAMPLE && pins_now != 2'h0 && !ignore;
  wire wdog_bite = wdog_cnt == 32'h0000_0001;
  wire slow_rise = slow_sync[2] == 1'b0 && slow_sync[1] == 1'b1;

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      rbl_pkg::RBL_ST_DRAIN: next_state = reset_now ? rbl_pkg::RBL_ST_HOLD : state;
      rbl_pkg::RBL_ST_HOLD: begin
        if (!reset_req && rst_cnt >= 8'(`RBL_RST_CYCLES - 1)) begin
          next_state = rbl_pkg::RBL_ST_SAMPLE;
        end
      end
      rbl_pkg::RBL_ST_SAMPLE: begin
        next_state = (pins_now == 2'h0 || ignore) ? rbl_pkg::RBL_ST_RUN : rbl_pkg::RBL_ST_ADDR_HI;
      end
      rbl_pkg::RBL_ST_RUN: next_state = reentry ? rbl_pkg::RBL_ST_ADDR_HI : state;
      rbl_pkg::RBL_ST_ADDR_HI: next_state = rx_valid ? rbl_pkg::RBL_ST_ADDR_LO : state;
      rbl_pkg::RBL_ST_ADDR_LO: next_state = rx_valid ? rbl_pkg::RBL_ST_DATA : state;
      rbl_pkg::RBL_ST_DATA: begin
        if (rx_valid) begin
          next_state = rbl_pkg::RBL_ST_SAMPLE; // back to rom start
        end
      end
      default: next_state = rbl_pkg::RBL_ST_DRAIN;
    endcase
    if (state != rbl_pkg::RBL_ST_DRAIN && state != rbl_pkg::RBL_ST_HOLD && reset_req) begin
      next_state = rbl_pkg::RBL_ST_DRAIN;
    end
    if (in_boot && ignore) begin
      next_state = rbl_pkg::RBL_ST_RUN;
    end
    if (wdog_bite) begin
      next_state = rbl_pkg::RBL_ST_HOLD;
    end
  end

  // state and reset counter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= rbl_pkg::RBL_ST_HOLD;
      rst_cnt <= 8'h00;
    end else begin
      state <= next_state;
      if (state != rbl_pkg::RBL_ST_HOLD || reset_req) begin
        rst_cnt <= 8'h00;
      end else if (rst_cnt != 8'hFF) begin
        rst_cnt <= rst_cnt + 8'h01;
      end
    end
  end

  // control register and boot mode latch
  always_ff @(posedge clock) begin
    if (!rst_n || in_reset) begin
      slave_port_boot_control <= `RBL_BOOT_CTRL_RESET;
      boot_mode <= 2'h0;
    end else begin
      if (ctrl_wr) begin
        slave_port_boot_control <= {new_ignore, 2'b00, pwdata[4:0]};
      end else if (state == rbl_pkg::RBL_ST_DATA && rx_valid && addr_hi[7]
        && {addr_hi[6:0], boot_wr_addr[7:0]} == 15'(`RBL_OFF_BOOT_CTRL)) begin
        slave_port_boot_control <= {rx_byte[7], 2'b00, rx_byte[4:0]};
      end
      if (enter_boot || reentry) begin
        boot_mode <= pins_now;
      end
    end
  end

  // triplet assembly and write strobes
  always_ff @(posedge clock) begin
    if (!rst_n || in_reset) begin
      addr_hi <= 8'h00;
      boot_wr <= 1'b0;
      boot_wr_reg <= 1'b0;
      boot_wr_addr <= `RBL_ZERO16;
      boot_wr_data <= 8'h00;
    end else begin
      boot_wr <= state == rbl_pkg::RBL_ST_DATA && rx_valid;
      if (state == rbl_pkg::RBL_ST_ADDR_HI && rx_valid) begin
        addr_hi <= rx_byte;
      end
      if (state == rbl_pkg::RBL_ST_ADDR_LO && rx_valid) begin
        boot_wr_addr <= {addr_hi, rx_byte};
      end
      if (state == rbl_pkg::RBL_ST_DATA && rx_valid) begin
        boot_wr_data <= rx_byte;
        boot_wr_reg <= boot_wr_addr[15];
      end
    end
  end

  // watchdog, reloaded by every boot byte
  always_ff @(posedge clock) begin
    if (!rst_n || in_reset) begin
      wdog_cnt <= WDOG_CYCLES;
      wdog_expired <= 1'b0;
    end else begin
      wdog_expired <= wdog_bite;
      if (in_boot && rx_valid) begin
        wdog_cnt <= WDOG_CYCLES;
      end else if (wdog_cnt != 32'h0000_0000) begin
        wdog_cnt <= wdog_cnt - 32'h0000_0001;
      end
    end
  end

  // baud tick from the 32 kHz clock, async serial boot only
  always_ff @(posedge clock) begin
    if (!rst_n || in_reset) begin
      baud_cnt <= 4'h0;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= 1'b0;
      if (boot_mode == 2'h3 && in_boot && slow_rise) begin
        if (baud_cnt == 4'(`RBL_BAUD_TICKS - 1)) begin
          baud_cnt <= 4'h0;
          baud_tick <= 1'b1;
        end else begin
          baud_cnt <= baud_cnt + 4'h1;
        end
      end
    end
  end

  // pin and configuration outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      init_active_out <= 1'b1;
      mem_select0_n <= 1'b1;
      mem_read_strobe0_n <= 1'b1;
      mem_select1_n_o <= 1'b1;
      mem_select1_n_oe <= 1'b0;
      io_ctrl_n <= 1'b1;
      core_reset <= 1'b1;
      boot_rom_active <= 1'b0;
      boot_port <= 2'h0;
      crypt_ram_clear <= 1'b0;
    end else begin
      init_active_out <= in_reset || powerdown;
      mem_select1_n_o <= 1'b1;
      mem_select1_n_oe <= !in_reset;
      io_ctrl_n <= 1'b1;
      mem_select0_n <= in_reset || in_boot || state == rbl_pkg::RBL_ST_SAMPLE;
      mem_read_strobe0_n <= in_reset || in_boot || state == rbl_pkg::RBL_ST_SAMPLE;
      core_reset <= in_reset;
      boot_rom_active <= in_boot;
      boot_port <= boot_mode;
      crypt_ram_clear <= enter_boot || reentry;
    end
  end

  // reset-time configuration values
  always_ff @(posedge clock) begin
    if (!rst_n || in_reset) begin
      cpu_clk_div <= `RBL_CLK_DIV8;
      per_clk_div <= `RBL_CLK_DIV8;
      doubler_en <= 1'b0;
      bank0_waits <= `RBL_BANK0_WAIT4;
      bank0_wprot <= 1'b1;
      mem_8bit <= 1'b1;
      pc_init <= `RBL_ZERO16;
      irq_priority_level <= `RBL_IRQ_PRIO_RESET;
      wdog_en <= 1'b1;
      sec_wdog_en <= 1'b0;
    end else begin
      wdog_en <= wdog_en;
    end
  end

  // apb read data and ready
  wire [31:0] rd_mux = hit_ctrl ? {24'h0, slave_port_boot_control[7], pins_now,
      slave_port_boot_control[4:0]}
    : reg_addr == `RBL_OFF_CPU_STATE ? {29'h0, state}
    : reg_addr == `RBL_OFF_CFG_STATE ? {24'h0, boot_mode, in_boot, init_active_out,
      doubler_en, cpu_clk_div, wdog_en}
    : reg_addr == `RBL_OFF_TRIPLET ? {8'h0, boot_wr_addr, boot_wr_data}
    : reg_addr == `RBL_OFF_RX_BYTE ? {24'h0, addr_hi}
    : reg_addr == `RBL_OFF_PC ? {16'h0, cpu_pc} : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !hit_ok;
      prdata <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // sequencer, pin and watchdog checks
  property p_rom; @(posedge clock) disable iff (!rst_n)
    in_boot |=> boot_rom_active && mem_select0_n && mem_read_strobe0_n; endproperty
  a_rom: assert property (p_rom) else $error("boot fetch not suppressed");
  property p_rst_len; @(posedge clock) disable iff (!rst_n) state == rbl_pkg::RBL_ST_HOLD
    ##1 state == rbl_pkg::RBL_ST_SAMPLE |-> $past(rst_cnt) >= 8'h7F; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset shorter than 128 cycles");
  property p_cs1; @(posedge clock) disable iff (!rst_n)
    in_reset |=> !mem_select1_n_oe && mem_select0_n && io_ctrl_n; endproperty
  a_cs1: assert property (p_cs1) else $error("controls not parked in reset");
  property p_init_active_out; @(posedge clock) disable iff (!rst_n)
    1'b1 |=> init_active_out == $past(in_reset || powerdown); endproperty
  a_init_active_out: assert property (p_init_active_out) else $error("reset indicator wrong");
  property p_defer; @(posedge clock) disable iff (!rst_n) write_busy && !wdog_bite
    && state == rbl_pkg::RBL_ST_DRAIN |=> state != rbl_pkg::RBL_ST_HOLD; endproperty
  a_defer: assert property (p_defer) else $error("reset cut a write");
  property p_boot; @(posedge clock) disable iff (!rst_n) state == rbl_pkg::RBL_ST_SAMPLE
    && pins_now != 2'h0 && !ignore && !reset_req && !wdog_bite
    |=> in_boot && crypt_ram_clear; endproperty
  a_boot: assert property (p_boot) else $error("boot entry missed");
  property p_norm; @(posedge clock) disable iff (!rst_n) state == rbl_pkg::RBL_ST_SAMPLE
    && pins_now == 2'h0 && !reset_req && !wdog_bite
    |=> state == rbl_pkg::RBL_ST_RUN; endproperty
  a_norm: assert property (p_norm) else $error("normal fetch missed");
  property p_erase; @(posedge clock) disable iff (!rst_n)
    reentry && !reset_req && !wdog_bite |=> crypt_ram_clear && in_boot; endproperty
  a_erase: assert property (p_erase) else $error("encryption ram not erased");
  property p_wdog; @(posedge clock) disable iff (!rst_n)
    in_boot && rx_valid && !in_reset |=> wdog_cnt == WDOG_CYCLES; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog not reloaded");
  c_boot: cover property (@(posedge clock) disable iff (!rst_n) boot_wr && boot_wr_reg);
  c_run: cover property (@(posedge clock) disable iff (!rst_n) state == rbl_pkg::RBL_ST_RUN);
  c_re: cover property (@(posedge clock) disable iff (!rst_n) reentry);
endmodule
`default_nettype wire

// ### tb/rbl_host_model.sv
// host loader model: feeds boot bytes to the block one pulse at a time
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ns
`default_nettype none
module rbl_host_model (
  input wire logic clock,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  // idle line shows the inverse of the last byte, never a stale copy
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end

  // one byte after gap edges; gap of at least one keeps pulses apart
  task automatic send_byte(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge clock);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
  endtask

  // address high, address low, then data
  task automatic send_triplet(input logic [15:0] a, input logic [7:0] d, input int gap);
    send_byte(a[15:8], gap);
    send_byte(a[7:0], gap);
    send_byte(d, gap);
  endtask
endmodule
`default_nettype wire

// ### tb/tb_rbl_reset_boot.sv
// self-checking bench for the reset and boot loader block
// assumes the design files and the host model compile first
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
`define WAITV(s, v, n) begin wk = 0; while ((s) !== (v) && wk < (n)) begin \
  @(negedge clock); wk++; end if ((s) !== (v)) begin `CHK(s, v) close_out(); end end
module tb_rbl_reset_boot;
  logic clock = 1'b0, rst_n = 1'b0, reset_pin_n = 1'b1, powerdown = 1'b0;
  logic write_busy = 1'b0, boot_select_pin0 = 1'b0, boot_select_pin1 = 1'b0;
  logic slow_clk_32k = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] cpu_pc = 16'h0000;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, init_active_out, mem_select0_n, mem_read_strobe0_n, er;
  logic mem_select1_n_o, mem_select1_n_oe, io_ctrl_n, core_reset, boot_rom_active;
  logic baud_tick, boot_wr, boot_wr_reg, crypt_ram_clear, doubler_en, bank0_wprot;
  logic mem_8bit, wdog_en, sec_wdog_en, wdog_expired, rx_valid;
  logic [1:0] boot_port, cpu_clk_div, per_clk_div;
  logic [15:0] boot_wr_addr, pc_init;
  logic [7:0] boot_wr_data, irq_priority_level, rx_byte;
  logic [2:0] bank0_waits;
  int n_fail = 0, samples_checked = 0, n_clear = 0, n_wdog = 0, n_baud = 0, base, nb, wk;

  rbl_reset_boot #(.WDOG_CYCLES(1000)) i_rbl_reset_boot (
    .clock, .rst_n, .reset_pin_n, .powerdown, .write_busy, .boot_select_pin0,
    .boot_select_pin1, .slow_clk_32k, .rx_valid, .rx_byte, .cpu_pc, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .init_active_out,
    .mem_select0_n, .mem_read_strobe0_n, .mem_select1_n_o, .mem_select1_n_oe,
    .io_ctrl_n, .core_reset, .boot_rom_active, .boot_port, .baud_tick, .boot_wr,
    .boot_wr_reg, .boot_wr_addr, .boot_wr_data, .crypt_ram_clear, .cpu_clk_div,
    .per_clk_div, .doubler_en, .bank0_waits, .bank0_wprot, .mem_8bit, .pc_init,
    .irq_priority_level, .wdog_en, .sec_wdog_en, .wdog_expired
  );
  rbl_host_model i_rbl_host_model (.clock, .rx_valid, .rx_byte);

  // main clock, and a sped-up slow clock so baud ticks come quickly
  always #5 clock = ~clock;
  always #25 slow_clk_32k = ~slow_clk_32k;

  // pulse counters
  always @(posedge clock) begin
    if (crypt_ram_clear === 1'b1) n_clear++;
    if (wdog_expired === 1'b1) n_wdog++;
    if (baud_tick === 1'b1) n_baud++;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // values read here are those the slave showed at this edge
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clock);
      k++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      `CHK(pready, 1'b1)
      close_out();
    end
  endtask

  // block reset with given boot pins; checks parked controls and length
  task automatic do_reset(input logic [1:0] pins);
    int k;
    k = 0;
    @(posedge clock);
    rst_n <= 1'b0;
    {boot_select_pin1, boot_select_pin0} <= pins;
    repeat (12) @(posedge clock);
    @(negedge clock);
    `CHK(init_active_out, 1'b1)
    `CHK(mem_select1_n_oe, 1'b0)
    `CHK({mem_select0_n, mem_read_strobe0_n, io_ctrl_n}, 3'h7)
    `CHK({core_reset, mem_select1_n_o}, 2'h3)
    @(posedge clock);
    rst_n <= 1'b1;
    while (init_active_out === 1'b1 && k < 400) begin
      @(negedge clock);
      k++;
    end
    `CHK(logic'(k >= 128), 1'b1)
    `CHK(init_active_out, 1'b0)
  endtask

  // main sequence
  initial begin
    do_reset(2'h0);
    `CHK({cpu_clk_div, per_clk_div}, 4'hF)
    `CHK({doubler_en, bank0_waits, bank0_wprot, mem_8bit}, 6'h13)
    `CHK(pc_init, 16'h0000)
    `CHK(irq_priority_level, 8'hFF)
    `CHK({wdog_en, sec_wdog_en}, 2'h2)
    // every boot pin code, ending in asynchronous serial boot
    for (int p = 0; p < 4; p++) begin
      base = n_clear;
      nb = n_baud;
      do_reset(p[1:0]);
      cyc(5);
      `CHK(boot_port, p[1:0])
      `CHK(boot_rom_active, logic'(p != 0))
      `CHK({core_reset, mem_select0_n}, {1'b0, logic'(p != 0)})
      `CHK(logic'(n_clear > base), logic'(p != 0))
      cyc(100);
      `CHK(logic'(n_baud > nb), logic'(p == 3))
    end
    // memory triplet, then register triplet setting the ignore bit
    i_rbl_host_model.send_triplet(16'h1234, 8'h5A, 2);
    `WAITV(boot_wr, 1'b1, 8)
    `CHK({boot_wr_reg, boot_wr_addr, boot_wr_data}, 25'h12_345A)
    i_rbl_host_model.send_triplet(16'h8024, 8'h80, 1);
    `WAITV(boot_wr, 1'b1, 8)
    `CHK(boot_wr_reg, 1'b1)
    `WAITV(boot_rom_active, 1'b0, 10)
    apb(1'b0, 32'h0000_0024, 32'h0000_0000, rd, er);
    `CHK({er, rd[7:5]}, 4'h7)
    apb(1'b0, 32'h0000_003C, 32'h0000_0000, rd, er);
    `CHK({er, rd}, 33'h1_0000_0000)
    // re-entry waits for a pc on a sixteen-byte boundary
    @(posedge clock);
    cpu_pc <= 16'h1235;
    base = n_clear;
    apb(1'b1, 32'h0000_0024, 32'h0000_0000, rd, er);
    cyc(10);
    `CHK(boot_rom_active, 1'b0)
    @(posedge clock);
    cpu_pc <= 16'h1240;
    `WAITV(boot_rom_active, 1'b1, 20)
    cyc(3);
    `CHK(logic'(n_clear > base), 1'b1)
    apb(1'b1, 32'h0000_0024, 32'h0000_0080, rd, er);
    `WAITV(boot_rom_active, 1'b0, 10)
    // powerdown raises the indicator
    @(posedge clock);
    powerdown <= 1'b1;
    cyc(4);
    `CHK(init_active_out, 1'b1)
    @(posedge clock);
    powerdown <= 1'b0;
    cyc(4);
    `CHK(init_active_out, 1'b0)
    // pin reset during a write waits for the write to end
    @(posedge clock);
    write_busy <= 1'b1;
    reset_pin_n <= 1'b0;
    cyc(20);
    `CHK({init_active_out, core_reset}, 2'h0)
    @(posedge clock);
    write_busy <= 1'b0;
    `WAITV(init_active_out, 1'b1, 10)
    @(posedge clock);
    reset_pin_n <= 1'b1;
    `WAITV(init_active_out, 1'b0, 400)
    apb(1'b0, 32'h0000_0024, 32'h0000_0000, rd, er);
    `CHK(rd[7], 1'b0)
    // slow bytes keep the watchdog fed, silence lets it expire
    base = n_wdog;
    repeat (3) i_rbl_host_model.send_byte(8'h00, 700);
    `CHK(n_wdog, base)
    cyc(1100);
    `CHK(logic'(n_wdog > base), 1'b1)
    close_out();
  end
endmodule
`default_nettype wire
